// ### hw/uart_rx_buffer.sv
// receive buffer and status logic of a serial port, axi4-lite register side
// assumes a recovery unit on core_clk_i delivering start and frame pulses
//
// Contract
// - done flag high exactly while fifo holds frames
// - clearing receiver enable empties the fifo
// - interrupt requested while done flag and enables set
// - data port read pops the oldest frame
// - error flags travel with their frame entry
// - error flags read-only, never raise interrupts
// - stop error equals inverted first stop bit
// - only first stop bit checked, count ignored
// - overrun when fifo full, hold busy, start
// - overrun pending clears on transfer into fifo
// - parity checked only when enabled, odd selectable
// - parity result stored with the frame entry
// - parity fail only if checked at arrival
// - disabling receiver abandons frame in progress at once
// - pin override released while receiver disabled
// - size seven gives nine bits, ninth bit shown
// - unused high data bits read as zero
`timescale 1ns/1ps
module uart_rx_buffer (
    input wire logic core_clk_i,
    input wire logic srst_i,
    // axi4-lite slave
    input wire logic [uart_rx_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [uart_rx_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // line side, from the recovery unit on the same clock
    input wire logic start_bit_i,
    input wire logic frame_valid_i,
    input wire uart_rx_pkg::line_frame_type frame_i,
    // system side
    input wire logic global_irq_en_i,
    output logic rx_done_irq_o,
    output logic rx_pin_override_o
);
    import uart_rx_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl_b;
        logic [7:0] ctrl_c;
        entry_type hold;
        logic hold_valid;
        logic ovr_pending;
        logic aw_full;
        logic [ADDR_W-1:0] awaddr;
        logic w_full;
        logic [7:0] wdata;
        logic wlane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
    } top_state_type;

    top_state_type st;
    top_state_type next_st;

    entry_type head;
    entry_type push_entry;
    entry_type new_entry;
    logic [1:0] fifo_count;
    logic rx_done;
    logic fifo_full;
    logic flush;
    logic push;
    logic pop;
    logic [2:0] csz;
    logic [8:0] data_mask;
    logic [8:0] masked;
    logic [7:0] status_byte;
    logic [7:0] ctrl_b_byte;
    logic [7:0] read_byte;

    // ----------------------------------------------------------------
    // receive fifo
    // ----------------------------------------------------------------
    uart_rx_fifo fifo_inst (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .push_i(push),
        .din_i(push_entry),
        .pop_i(pop),
        .flush_i(flush),
        .head_o(head),
        .count_o(fifo_count)
    );

    // ----------------------------------------------------------------
    // frame check: width mask, parity and stop bit
    // ----------------------------------------------------------------
    // sizes four to six are not defined; they are treated as eight bits
    always_comb begin
        csz = st.ctrl_c[CSZ_LSB +: 3];
        if (csz == CSZ_NINE) begin
            data_mask = 9'h1ff;
        end else if (csz <= CSZ_EIGHT) begin
            data_mask = 9'h1ff >> (3'h4 - csz);
        end else begin
            data_mask = 9'h0ff;
        end
        masked = frame_i.data & data_mask;
        new_entry.data = masked[7:0];
        new_entry.ninth = masked[8];
        new_entry.stop_err = ~frame_i.stop1;
        new_entry.overrun = 1'b0;
        // even parity fails on an odd count of ones, odd parity the other way
        new_entry.parity_fail = st.ctrl_c[PARITY_ON_POS]
            & (^masked ^ frame_i.parity ^ st.ctrl_c[PARITY_ODD_POS]);
    end

    // ----------------------------------------------------------------
    // readable views of status and control
    // ----------------------------------------------------------------
    always_comb begin
        status_byte = 8'h00;
        status_byte[RX_DONE_POS] = rx_done;
        status_byte[STOP_ERR_POS] = head.stop_err & rx_done;
        status_byte[OVERRUN_POS] = head.overrun & rx_done;
        status_byte[PARITY_FAIL_POS] = head.parity_fail & rx_done;
        ctrl_b_byte = st.ctrl_b;
        ctrl_b_byte[NINTH_POS] = head.ninth & rx_done;
    end

    assign rx_done = (fifo_count != 2'h0);
    assign fifo_full = (fifo_count == 2'h2);
    assign flush = ~st.ctrl_b[RX_EN_POS];

    // ----------------------------------------------------------------
    // next state: line side, register writes, register reads
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        pop = 1'b0;
        read_byte = 8'h00;

        // hold stage plays the shift register: it drains as soon as a slot frees
        push = st.hold_valid && !fifo_full && !flush;
        push_entry = st.hold;
        push_entry.overrun = st.ovr_pending;
        next_st.hold_valid = st.hold_valid && !push;
        if (push) begin
            next_st.ovr_pending = 1'b0;
        end
        // a newly finished frame replaces a held one lost to overrun
        if (frame_valid_i && !flush) begin
            next_st.hold = new_entry;
            next_st.hold_valid = 1'b1;
        end
        // set wins over the clear from a transfer in the same cycle
        if (start_bit_i && fifo_full && st.hold_valid && !flush) begin
            next_st.ovr_pending = 1'b1;
        end
        // disabled receiver drops the held frame and all pending status
        if (flush) begin
            next_st.hold_valid = 1'b0;
            next_st.ovr_pending = 1'b0;
        end

        // write address and data are taken in either order
        if (s_axi_awvalid_i && st.awready) begin
            next_st.aw_full = 1'b1;
            next_st.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && st.wready) begin
            next_st.w_full = 1'b1;
            next_st.wdata = s_axi_wdata_i[7:0];
            next_st.wlane0 = s_axi_wstrb_i[0];
        end
        if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid = 1'b0;
        end
        // only byte lane zero carries register bits
        if (st.aw_full && st.w_full && !st.bvalid) begin
            next_st.aw_full = 1'b0;
            next_st.w_full = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            unique case (st.awaddr)
                CTRL_B_OFFS: begin
                    if (st.wlane0) begin
                        next_st.ctrl_b = (st.ctrl_b & ~CTRL_B_WMASK)
                            | (st.wdata & CTRL_B_WMASK);
                    end
                end
                CTRL_C_OFFS: begin
                    if (st.wlane0) begin
                        next_st.ctrl_c = (st.ctrl_c & ~CTRL_C_WMASK)
                            | (st.wdata & CTRL_C_WMASK);
                    end
                end
                // error flags are stored in the fifo, so writes cannot touch them
                STATUS_A_OFFS: next_st.bresp = RESP_OKAY;
                DATA_PORT_OFFS: next_st.bresp = RESP_OKAY;
                default: next_st.bresp = RESP_SLVERR;
            endcase
        end

        // reads: one outstanding, answer one cycle after the address is taken
        if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            unique case (s_axi_araddr_i)
                DATA_PORT_OFFS: begin
                    read_byte = rx_done ? head.data : 8'h00;
                    pop = rx_done && !flush;
                end
                STATUS_A_OFFS: read_byte = status_byte;
                CTRL_B_OFFS: read_byte = ctrl_b_byte;
                CTRL_C_OFFS: read_byte = st.ctrl_c;
                default: next_st.rresp = RESP_SLVERR;
            endcase
            next_st.rdata = {24'h000000, read_byte};
        end

        next_st.awready = !next_st.aw_full;
        next_st.wready = !next_st.w_full;
        next_st.arready = !next_st.rvalid;
        // only the done flag can request; error flags never do
        next_st.irq = rx_done && st.ctrl_b[IRQ_EN_POS] && global_irq_en_i;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st <= '0;
            st.ctrl_b <= CTRL_B_RESET;
            st.ctrl_c <= CTRL_C_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs, each straight from the state register
    // ----------------------------------------------------------------
    assign s_axi_awready_o = st.awready;
    assign s_axi_wready_o = st.wready;
    assign s_axi_bresp_o = st.bresp;
    assign s_axi_bvalid_o = st.bvalid;
    assign s_axi_arready_o = st.arready;
    assign s_axi_rdata_o = st.rdata;
    assign s_axi_rresp_o = st.rresp;
    assign s_axi_rvalid_o = st.rvalid;
    assign rx_done_irq_o = st.irq;
    assign rx_pin_override_o = st.ctrl_b[RX_EN_POS];
endmodule

// ### hw/uart_rx_fifo.sv
// two-entry receive fifo holding frames and their status
// assumes the caller never pushes while full; pops on empty are ignored
`timescale 1ns/1ps
module uart_rx_fifo (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic push_i,
    input wire uart_rx_pkg::entry_type din_i,
    input wire logic pop_i,
    input wire logic flush_i,
    output uart_rx_pkg::entry_type head_o,
    output logic [1:0] count_o
);
    import uart_rx_pkg::*;

    typedef struct packed {
        entry_type [FIFO_DEPTH-1:0] mem;
        logic rd;
        logic wr;
        logic [1:0] count;
    } fifo_state_type;

    fifo_state_type st;
    fifo_state_type next_st;
    logic do_pop;
    logic do_push;

    // ----------------------------------------------------------------
    // pointer and storage update
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        do_pop = pop_i && (st.count != 2'h0);
        do_push = push_i && (st.count != 2'h2);
        if (do_push) begin
            next_st.mem[st.wr] = din_i;
            next_st.wr = ~st.wr;
        end
        if (do_pop) begin
            next_st.rd = ~st.rd;
        end
        next_st.count = st.count + {1'b0, do_push} - {1'b0, do_pop};
        // flush wins over everything: unread frames are discarded
        if (flush_i) begin
            next_st.rd = 1'b0;
            next_st.wr = 1'b0;
            next_st.count = 2'h0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign head_o = st.mem[st.rd];
    assign count_o = st.count;
endmodule

// ### hw/uart_rx_pkg.sv
// shared constants and types of the serial receive buffer and status block
// assumes a 32-bit axi4-lite register side and a same-clock frame recovery unit
package uart_rx_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] DATA_PORT_OFFS = 8'h00;
    localparam logic [7:0] STATUS_A_OFFS = 8'h04;
    localparam logic [7:0] CTRL_B_OFFS = 8'h08;
    localparam logic [7:0] CTRL_C_OFFS = 8'h0c;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int RX_DONE_POS = 7;
    localparam int STOP_ERR_POS = 4;
    localparam int OVERRUN_POS = 3;
    localparam int PARITY_FAIL_POS = 2;
    localparam int IRQ_EN_POS = 7;
    localparam int RX_EN_POS = 4;
    localparam int NINTH_POS = 1;
    localparam int PARITY_ON_POS = 5;
    localparam int PARITY_ODD_POS = 4;
    localparam int STOP_CNT_POS = 3;
    localparam int CSZ_LSB = 0;

    // writable bits of the control registers
    localparam logic [7:0] CTRL_B_WMASK = 8'h90;
    localparam logic [7:0] CTRL_C_WMASK = 8'h3f;

    // ----------------------------------------------------------------
    // reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    localparam logic [7:0] CTRL_C_RESET = 8'h03;
    localparam logic [2:0] CSZ_NINE = 3'h7;
    localparam logic [2:0] CSZ_EIGHT = 3'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int FIFO_DEPTH = 2;

    // one completed frame as the recovery unit hands it over
    typedef struct packed {
        logic [8:0] data;
        logic parity;
        logic stop1;
    } line_frame_type;

    // one receive fifo entry: data with its own status
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic stop_err;
        logic overrun;
        logic parity_fail;
    } entry_type;

endpackage

// ### test/tb_top.sv
// self-checking bench for the receive buffer over axi4-lite
// assumes the line model drives the recovery side on the core clock
`timescale 1ns/1ps
module tb_top;
    import uart_rx_pkg::*;
    logic core_clk_i, srst_i, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr, gie, irq, pin;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd_d;
    logic [1:0] bresp, rresp;
    logic sb, fv;
    line_frame_type fr;
    int n_mismatch, tests_run;
    uart_line_model line (.core_clk_i, .start_bit_o(sb), .frame_valid_o(fv), .frame_o(fr));
    uart_rx_buffer dut (.core_clk_i, .srst_i, .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rd_d), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
        .start_bit_i(sb), .frame_valid_i(fv), .frame_i(fr), .global_irq_en_i(gie),
        .rx_done_irq_o(irq), .rx_pin_override_o(pin));
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    // ------------------------------------------------------------
    // compare, expectation and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk({30'h0, got}, {30'h0, exp});
    endtask
    function automatic logic [7:0] stat(input logic fe, input logic ov, input logic pf);
        return {1'b1, 2'b00, fe, ov, pf, 2'b00};
    endfunction
    function automatic logic pfail(input logic [7:0] d, input logic p, input logic [7:0] cc);
        return cc[PARITY_ON_POS] & (^d ^ p ^ cc[PARITY_ODD_POS]);
    endfunction
    // both write channels offered together, each released at its own take
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        bit ad, dd;
        @(posedge core_clk_i);
        awa <= a; awv <= 1'b1; wd <= {24'h0, d}; wv <= 1'b1;
        ad = 0; dd = 0;
        while (!(ad && dd)) begin
            @(posedge core_clk_i);
            if (!ad && awr === 1'b1) begin ad = 1; awv <= 1'b0; end
            if (!dd && wr_rdy === 1'b1) begin dd = 1; wv <= 1'b0; end
        end
        do @(posedge core_clk_i); while (bv !== 1'b1);
        // late ready makes the response stand one extra cycle
        br <= 1'b1;
        @(posedge core_clk_i);
        br <= 1'b0;
        chk_resp(bresp, er);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
        @(posedge core_clk_i);
        ara <= a; arv <= 1'b1;
        do @(posedge core_clk_i); while (arr !== 1'b1);
        arv <= 1'b0;
        // ready comes one cycle late so the read answer has to stand
        @(posedge core_clk_i);
        rr <= 1'b1;
        do @(posedge core_clk_i); while (rv !== 1'b1);
        rr <= 1'b0;
        chk(rd_d, {24'h0, exp});
        chk_resp(rresp, er);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles the tests take
    initial begin
        repeat (40000) @(posedge core_clk_i);
        n_mismatch++;
        print_verdict();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [8:0] d;
        logic [8:0] q[4];
        logic p;
        logic [7:0] cc[3];
        cc = '{8'h03, 8'h23, 8'h33};
        {awv, wv, br, arv, rr, gie, awa, ara, wd} = '0;
        n_mismatch = 0; tests_run = 0; srst_i = 1'b1;
        void'($urandom(24285));
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'b0;
        rdc(CTRL_B_OFFS, CTRL_B_RESET, RESP_OKAY);
        rdc(CTRL_C_OFFS, CTRL_C_RESET, RESP_OKAY);
        rdc(8'h10, 8'h00, RESP_SLVERR);
        wr(8'h10, 8'hff, RESP_SLVERR);
        chk(pin, 1'b0);
        $display("reset and map test finished");
        gie <= 1'b1;
        wr(CTRL_B_OFFS, 8'h90, RESP_OKAY);
        chk(pin, 1'b1);
        rdc(DATA_PORT_OFFS, 8'h00, RESP_OKAY);
        rdc(STATUS_A_OFFS, 8'h00, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            d = 9'($urandom);
            gie <= i[0];
            line.send(d, 1'b0, 1'b1, i);
            repeat (4) @(posedge core_clk_i);
            chk(irq, i[0]);
            rdc(STATUS_A_OFFS, stat(0, 0, 0), RESP_OKAY);
            rdc(DATA_PORT_OFFS, d[7:0], RESP_OKAY);
            repeat (2) @(posedge core_clk_i);
            chk(irq, 1'b0);
            rdc(STATUS_A_OFFS, 8'h00, RESP_OKAY);
        end
        gie <= 1'b1;
        $display("receive and interrupt test finished");
        wr(CTRL_C_OFFS, 8'h0b, RESP_OKAY);
        for (int s = 0; s < 2; s++) begin
            d = 9'($urandom);
            line.send(d, 1'b0, s[0], 1);
            rdc(STATUS_A_OFFS, stat(!s[0], 0, 0), RESP_OKAY);
            rdc(DATA_PORT_OFFS, d[7:0], RESP_OKAY);
        end
        $display("stop bit test finished");
        for (int m = 0; m < 6; m++) begin
            d = 9'($urandom);
            p = 1'($urandom);
            wr(CTRL_C_OFFS, cc[m % 3], RESP_OKAY);
            line.send(d, p, 1'b1, 2);
            // checking mode at arrival counts, not the mode at read
            wr(CTRL_C_OFFS, 8'h03, RESP_OKAY);
            rdc(STATUS_A_OFFS, stat(0, 0, pfail(d[7:0], p, cc[m % 3])), RESP_OKAY);
            rdc(DATA_PORT_OFFS, d[7:0], RESP_OKAY);
        end
        $display("parity test finished");
        foreach (q[i]) begin
            q[i] = 9'($urandom);
            line.send(q[i], 1'b0, 1'b1, 1);
        end
        rdc(STATUS_A_OFFS, stat(0, 0, 0), RESP_OKAY);
        rdc(DATA_PORT_OFFS, q[0][7:0], RESP_OKAY);
        rdc(STATUS_A_OFFS, stat(0, 0, 0), RESP_OKAY);
        rdc(DATA_PORT_OFFS, q[1][7:0], RESP_OKAY);
        rdc(STATUS_A_OFFS, stat(0, 1, 0), RESP_OKAY);
        rdc(DATA_PORT_OFFS, q[3][7:0], RESP_OKAY);
        rdc(STATUS_A_OFFS, 8'h00, RESP_OKAY);
        line.send(9'h0a5, 1'b0, 1'b1, 1);
        rdc(STATUS_A_OFFS, stat(0, 0, 0), RESP_OKAY);
        rdc(DATA_PORT_OFFS, 8'ha5, RESP_OKAY);
        $display("overrun test finished");
        wr(CTRL_C_OFFS, {5'h0, CSZ_NINE}, RESP_OKAY);
        d = 9'($urandom) | 9'h100;
        line.send(d, 1'b0, 1'b1, 1);
        rdc(CTRL_B_OFFS, 8'h92, RESP_OKAY);
        rdc(DATA_PORT_OFFS, d[7:0], RESP_OKAY);
        wr(CTRL_C_OFFS, 8'h00, RESP_OKAY);
        line.send(9'h1ff, 1'b0, 1'b1, 1);
        rdc(DATA_PORT_OFFS, 8'h1f, RESP_OKAY);
        $display("character size test finished");
        wr(CTRL_C_OFFS, 8'h03, RESP_OKAY);
        line.send(9'h03c, 1'b0, 1'b0, 1);
        wr(STATUS_A_OFFS, 8'h00, RESP_OKAY);
        wr(DATA_PORT_OFFS, 8'h55, RESP_OKAY);
        rdc(STATUS_A_OFFS, stat(1, 0, 0), RESP_OKAY);
        line.send(9'h0c3, 1'b0, 1'b1, 1);
        wr(CTRL_B_OFFS, 8'h80, RESP_OKAY);
        rdc(STATUS_A_OFFS, 8'h00, RESP_OKAY);
        chk({irq, pin}, 2'b00);
        line.send(9'h033, 1'b0, 1'b1, 1);
        wr(CTRL_B_OFFS, 8'h90, RESP_OKAY);
        rdc(STATUS_A_OFFS, 8'h00, RESP_OKAY);
        $display("flush test finished");
        print_verdict();
    end
endmodule

// ### test/uart_line_model.sv
// frame recovery model on the line side, same clock as the block
// assumes callers leave at least two cycles between frames
`timescale 1ns/1ps
module uart_line_model (
    input wire logic core_clk_i,
    output logic start_bit_o,
    output logic frame_valid_o,
    output uart_rx_pkg::line_frame_type frame_o
);
    import uart_rx_pkg::*;
    initial begin
        start_bit_o = 1'b0;
        frame_valid_o = 1'b0;
        frame_o = '0;
    end
    // start pulse, gap cycles of bit time, then the frame with its first stop bit
    task automatic send(input logic [8:0] d, input logic p, input logic s1, input int gap);
        @(posedge core_clk_i) start_bit_o <= 1'b1;
        @(posedge core_clk_i) start_bit_o <= 1'b0;
        repeat (gap) @(posedge core_clk_i);
        frame_valid_o <= 1'b1;
        frame_o <= '{data: d, parity: p, stop1: s1};
        // invert afterwards so a stale frame never looks valid by accident
        @(posedge core_clk_i) frame_valid_o <= 1'b0;
        frame_o <= ~frame_o;
    endtask
endmodule

// ### test/uart_rx_buffer_monitor.sv
// port checker for the receive buffer block
// assumes one core clock and the synchronous active-high reset
`timescale 1ns/1ps
module uart_rx_buffer_monitor
    import uart_rx_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic global_irq_en_i,
    input wire logic rx_done_irq_o,
    input wire logic rx_pin_override_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // ------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------
    property p_reset_quiet;
        $fell(srst_i) |-> !s_axi_bvalid_o && !s_axi_rvalid_o && !rx_done_irq_o;
    endproperty
    property p_read_lat;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
    endproperty
    property p_read_hold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    property p_unmapped;
        s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 8'h0c
            |=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0;
    endproperty
    property p_write_resp;
        // both slots fill at the take edge, the response is built one edge later
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
            |-> ##2 s_axi_bvalid_o;
    endproperty
    property p_bresp_hold;
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    property p_high_zero;
        s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0;
    endproperty
    // ------------------------------------------------------------
    // interrupt and pin
    // ------------------------------------------------------------
    property p_irq_global;
        !global_irq_en_i |=> !rx_done_irq_o;
    endproperty
    // flush while disabled must have dropped the request by the third cycle
    property p_irq_off_rx;
        !rx_pin_override_o [*3] |-> !rx_done_irq_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    a_read_lat: assert property (p_read_lat) else $error("read answer late");
    a_read_hold: assert property (p_read_hold) else $error("read data dropped early");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    a_write_resp: assert property (p_write_resp) else $error("write answer late");
    a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");
    a_high_zero: assert property (p_high_zero) else $error("high read bits set");
    a_irq_global: assert property (p_irq_global) else $error("irq while masked");
    a_irq_off_rx: assert property (p_irq_off_rx) else $error("irq while disabled");
    c_irq: cover property ($rose(rx_done_irq_o));
    c_bad_read: cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);
    c_write: cover property (s_axi_bvalid_o && s_axi_bready_i);
endmodule

bind uart_rx_buffer uart_rx_buffer_monitor mon (.core_clk_i, .srst_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .global_irq_en_i, .rx_done_irq_o,
    .rx_pin_override_o);
